// ### verilog/frj_exec.sv
// Execution of watchdog clear, file clear, invert, decrement,
// decrement-and-skip and jump, with the datapath state they touch.
// Assumes one instruction word per valid cycle from the fetch stage,
// and a register port with one-cycle strobes and read data one cycle later.
// Words outside the six handled here only advance the fetch address.
// A port write loses to an instruction that updates the same target that cycle.
// The fetch address offsets are read-only from the port.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module frj_exec
  import frj_pkg::*;
(
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  // Instruction stream
  input  wire logic                         instr_valid,
  input  wire logic [frj_pkg::WORD_W-1:0]   instr_word,
  // Register port
  input  wire logic [frj_pkg::RADR_W-1:0]   reg_addr,
  input  wire logic [frj_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [frj_pkg::DATA_W-1:0]   reg_rdata,
  // Datapath state
  output logic      [frj_pkg::PROG_W-1:0]   program_counter,
  output logic      [frj_pkg::DATA_W-1:0]   work_reg,
  output logic      [frj_pkg::DATA_W-1:0]   status_reg,
  output logic      [frj_pkg::DATA_W-1:0]   watchdog_counter,
  output logic      [frj_pkg::DATA_W-1:0]   prescaler,
  output logic                              flush_active
);

  import frj_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  frj_state_t                state;
  frj_state_t                next_state;
  frj_aluop_t                alu_op;
  logic [DATA_W-1:0]         file_mem [FILE_N];
  logic [DATA_W-1:0]         option_reg;
  logic [DATA_W-1:0]         alu_result;
  logic                      alu_zero;
  logic [DATA_W-1:0]         file_operand;
  logic [FADR_W-1:0]         file_addr;
  logic                      dest_file;
  logic                      exec;
  logic                      is_wdog_clr;
  logic                      is_clear;
  logic                      is_invert;
  logic                      is_dec;
  logic                      is_decsk;
  logic                      is_jump;
  logic                      uses_alu;
  logic                      write_file;
  logic                      write_work;
  logic                      touch_zero;
  logic                      take_skip;
  logic [PROG_W-1:0]         jump_target;
  logic                      bus_file;
  logic [DATA_W-1:0]         next_rdata;
  logic                      wr_work;
  logic                      wr_status;
  logic                      wr_option;
  logic                      wr_watchdog;
  logic                      wr_prescale;

  ////////////////////////////////////////////////////////////////////////////
  // Decode; during a flush slot the word is discarded and acts as a no-op
  assign exec         = instr_valid && (state == FRJ_ST_EXEC);
  assign is_wdog_clr  = exec && (instr_word == OP_WDOG_CLR);
  assign is_clear     = exec && (instr_word[WORD_W-1:F_CLEAR_LSB] == OP_CLEAR_HI);
  assign is_invert    = exec && (instr_word[WORD_W-1:F_OP6_LSB] == OP_INVERT_HI);
  assign is_dec       = exec && (instr_word[WORD_W-1:F_OP6_LSB] == OP_DEC_HI);
  assign is_decsk     = exec && (instr_word[WORD_W-1:F_OP6_LSB] == OP_DECSK_HI);
  assign is_jump      = exec && (instr_word[WORD_W-1:F_JUMP_LSB] == OP_JUMP_HI);

  // Operand fields
  assign file_addr = instr_word[F_ADDR_LSB +: FADR_W];
  assign dest_file = instr_word[F_DEST_BIT];
  assign file_operand = file_mem[file_addr];

  ////////////////////////////////////////////////////////////////////////////
  // Operation select for the result unit
  always_comb begin
    if (is_invert) begin
      alu_op = FRJ_ALU_INVERT;
    end else if (is_dec || is_decsk) begin
      alu_op = FRJ_ALU_DEC;
    end else begin
      alu_op = FRJ_ALU_CLEAR;
    end
  end

  frj_alu u_alu (
    .op      (alu_op),
    .operand (file_operand),
    .result  (alu_result),
    .is_zero (alu_zero)
  );

  // Destination steering; clear always targets the file
  assign uses_alu   = is_invert || is_dec || is_decsk;
  assign write_file = is_clear || (uses_alu && dest_file);
  assign write_work = uses_alu && !dest_file;

  // Skip variant is left out here, so its flags stay put
  assign touch_zero = is_clear || is_invert || is_dec;
  assign take_skip  = is_decsk && alu_zero;

  // Page bits come from status, low bits from the operand
  assign jump_target = {status_reg[ST_PAGE_MSB:ST_PAGE_LSB],
                        instr_word[F_JUMP_MSB:0]};

  // Register port hits the file when the top bits are clear
  assign bus_file = (reg_addr <= OFS_FILE_LAST);

  // Port write enables for the registers outside the file
  assign wr_work     = reg_wr && (reg_addr == OFS_WORK);
  assign wr_status   = reg_wr && (reg_addr == OFS_STATUS);
  assign wr_option   = reg_wr && (reg_addr == OFS_OPTION);
  assign wr_watchdog = reg_wr && (reg_addr == OFS_WATCHDOG);
  assign wr_prescale = reg_wr && (reg_addr == OFS_PRESCALE);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: a skip or jump costs the next slot
  always_comb begin
    next_state = state;
    case (state)
      FRJ_ST_EXEC: begin
        if (take_skip || is_jump) begin
          next_state = FRJ_ST_FLUSH;
        end
      end
      FRJ_ST_FLUSH: begin
        // Wait for the dropped word; fetch may stall between words
        if (instr_valid) begin
          next_state = FRJ_ST_EXEC;
        end
      end
      default: next_state = FRJ_ST_EXEC;
    endcase
  end

  // Sequencer state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= FRJ_ST_EXEC;
    end else begin
      state <= next_state;
    end
  end

  // Flush flag mirrors the state; kept apart so the output is its own flop
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flush_active <= 1'b0;
    end else begin
      flush_active <= (next_state == FRJ_ST_FLUSH);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter; a dropped word still advances the fetch address
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      program_counter <= PROG_RST;
    end else if (is_jump) begin
      program_counter <= jump_target;
    end else if (instr_valid) begin
      program_counter <= program_counter + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File registers; the instruction beats a same-cycle port write
  generate
    for (genvar gi = 0; gi < FILE_N; gi++) begin : g_file
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          file_mem[gi] <= ZERO_BYTE;
        end else if (write_file && (file_addr == FADR_W'(gi))) begin
          file_mem[gi] <= alu_result;
        end else if (reg_wr && bus_file && (reg_addr[FADR_W-1:0] == FADR_W'(gi))) begin
          file_mem[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Working register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      work_reg <= ZERO_BYTE;
    end else if (write_work) begin
      work_reg <= alu_result;
    end else if (wr_work) begin
      work_reg <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status; instruction updates override a port write that cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_reg <= STATUS_RST;
    end else if (is_wdog_clr) begin
      status_reg[ST_TIMEOUT_N] <= 1'b1;
      status_reg[ST_PWRDOWN_N] <= 1'b1;
    end else if (touch_zero) begin
      status_reg[ST_ZERO] <= alu_zero;
    end else if (wr_status) begin
      status_reg <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option register; only the assignment bit matters to this block
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      option_reg <= OPTION_RST;
    end else if (wr_option) begin
      option_reg <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog counter; its timeout path lives outside this block
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      watchdog_counter <= ZERO_BYTE;
    end else if (is_wdog_clr) begin
      watchdog_counter <= ZERO_BYTE;
    end else if (wr_watchdog) begin
      watchdog_counter <= reg_wdata;
    end
  end

  // Shared prescaler; left alone while it serves the tick counter
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prescaler <= ZERO_BYTE;
    end else if (is_wdog_clr && option_reg[OPT_PSA]) begin
      prescaler <= ZERO_BYTE;
    end else if (wr_prescale) begin
      prescaler <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read select; zero whenever no read strobe is present
  always_comb begin
    next_rdata = ZERO_BYTE;
    if (!reg_rd) begin
      next_rdata = ZERO_BYTE;
    end else if (bus_file) begin
      next_rdata = file_mem[reg_addr[FADR_W-1:0]];
    end else if (reg_addr == OFS_WORK) begin
      next_rdata = work_reg;
    end else if (reg_addr == OFS_STATUS) begin
      next_rdata = status_reg;
    end else if (reg_addr == OFS_OPTION) begin
      next_rdata = option_reg;
    end else if (reg_addr == OFS_WATCHDOG) begin
      next_rdata = watchdog_counter;
    end else if (reg_addr == OFS_PRESCALE) begin
      next_rdata = prescaler;
    end else if (reg_addr == OFS_PROG_LO) begin
      next_rdata = program_counter[DATA_W-1:0];
    end else if (reg_addr == OFS_PROG_HI) begin
      // Upper bits read as zero
      next_rdata = {5'h00, program_counter[PROG_W-1:DATA_W]};
    end else begin
      // Unmapped offsets read as zero
      next_rdata = ZERO_BYTE;
    end
  end

  // Read data flop; stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= ZERO_BYTE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // frj_exec

`default_nettype wire

// ### verilog/frj_pkg.sv
// Package for the file-register and jump execution block.
// Holds opcode patterns, field positions, register offsets and reset values.
// Assumes a 12-bit instruction word and an 8-bit datapath.
package frj_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int WORD_W = 12;
  localparam int DATA_W = 8;
  localparam int PROG_W = 11;
  localparam int FILE_N = 32;
  localparam int FADR_W = 5;
  localparam int RADR_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode patterns
  localparam logic [11:0] OP_WDOG_CLR  = 12'h004;
  localparam logic [6:0]  OP_CLEAR_HI  = 7'h03;  // Bits 11:5
  localparam logic [5:0]  OP_INVERT_HI = 6'h09;  // Bits 11:6
  localparam logic [5:0]  OP_DEC_HI    = 6'h03;  // Bits 11:6
  localparam logic [5:0]  OP_DECSK_HI  = 6'h0b;  // Bits 11:6
  localparam logic [2:0]  OP_JUMP_HI   = 3'h5;   // Bits 11:9

  // Instruction field positions
  localparam int F_DEST_BIT  = 5;
  localparam int F_ADDR_LSB  = 0;
  localparam int F_JUMP_MSB  = 8;
  localparam int F_CLEAR_LSB = 5;
  localparam int F_OP6_LSB   = 6;
  localparam int F_JUMP_LSB  = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Status and option field positions
  localparam int ST_PAGE_MSB   = 6;
  localparam int ST_PAGE_LSB   = 5;
  localparam int ST_TIMEOUT_N  = 4;
  localparam int ST_PWRDOWN_N  = 3;
  localparam int ST_ZERO       = 2;
  localparam int OPT_PSA       = 3;  // 1: prescaler on watchdog

  // Reset values
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [7:0]  OPTION_RST = 8'hff;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;
  localparam logic [10:0] PROG_RST   = 11'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Register port offsets; 0x00 to 0x1f are the file registers
  localparam logic [7:0] OFS_FILE_LAST = 8'h1f;
  localparam logic [7:0] OFS_WORK      = 8'h20;
  localparam logic [7:0] OFS_STATUS    = 8'h21;
  localparam logic [7:0] OFS_OPTION    = 8'h22;
  localparam logic [7:0] OFS_WATCHDOG  = 8'h23;
  localparam logic [7:0] OFS_PRESCALE  = 8'h24;
  localparam logic [7:0] OFS_PROG_LO   = 8'h25;
  localparam logic [7:0] OFS_PROG_HI   = 8'h26;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    FRJ_ALU_CLEAR,
    FRJ_ALU_INVERT,
    FRJ_ALU_DEC
  } frj_aluop_t;

  typedef enum logic {
    FRJ_ST_EXEC,
    FRJ_ST_FLUSH
  } frj_state_t;

endpackage

// ### verilog/frj_alu.sv
// Result unit for the file-register instructions.
// Purely combinational; the caller registers the result and the flag.
`timescale 1ns/1ps
`default_nettype none

module frj_alu
  import frj_pkg::*;
(
  // Operation and operand
  input  wire frj_pkg::frj_aluop_t          op,
  input  wire logic [frj_pkg::DATA_W-1:0]   operand,
  // Result
  output logic      [frj_pkg::DATA_W-1:0]   result,
  output logic                              is_zero
);

  ////////////////////////////////////////////////////////////////////////////
  // Result select; decrement wraps 00h to ffh
  always_comb begin
    case (op)
      FRJ_ALU_CLEAR:  result = ZERO_BYTE;
      FRJ_ALU_INVERT: result = ~operand;
      FRJ_ALU_DEC:    result = operand - 8'h01;
      default:        result = ZERO_BYTE;
    endcase
  end

  // Zero detect on the full 8-bit result
  assign is_zero = (result == ZERO_BYTE);

endmodule // frj_alu

`default_nettype wire

// ### sim/frj_exec_monitor.sv
// Port assertions for the file-register and jump execution block.
// Assumes a bind from the testbench top onto frj_exec, one clock domain.
`timescale 1ns/1ps
`default_nettype none

module frj_exec_monitor
  import frj_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // Instruction stream
  input wire logic        instr_valid,
  input wire logic [11:0] instr_word,
  // Datapath state
  input wire logic [10:0] program_counter,
  input wire logic [7:0]  work_reg,
  input wire logic [7:0]  status_reg,
  input wire logic [7:0]  watchdog_counter,
  input wire logic        flush_active
);
  // Executed words only; a word in a flush slot is a no-op
  logic        take, is_wdc, is_clr, is_inv, is_dec, is_dsk, is_jmp;
  logic [10:0] jump_dest;
  assign take      = instr_valid && !flush_active;
  assign is_wdc    = take && instr_word == OP_WDOG_CLR;
  assign is_clr    = take && instr_word[11:5] == OP_CLEAR_HI;
  assign is_inv    = take && instr_word[11:6] == OP_INVERT_HI && !instr_word[5];
  assign is_dec    = take && instr_word[11:6] == OP_DEC_HI && !instr_word[5];
  assign is_dsk    = take && instr_word[11:6] == OP_DECSK_HI;
  assign is_jmp    = take && instr_word[11:9] == OP_JUMP_HI;
  assign jump_dest = {status_reg[6:5], instr_word[8:0]};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Jump taken, then its flush slot filled by a valid word
  sequence s_jump_slot;
    is_jmp ##1 (flush_active && instr_valid);
  endsequence

  a_wdog_clear: assert property (is_wdc |=>
    watchdog_counter == 8'h00 && status_reg[4:3] == 2'b11) else $error("watchdog clear wrong");
  a_clear_zero: assert property (is_clr |=> status_reg[ST_ZERO])
    else $error("clear left zero flag low");
  a_invert_zero: assert property (is_inv |=>
    status_reg[ST_ZERO] == (work_reg == 8'h00)) else $error("invert zero flag wrong");
  a_dec_zero: assert property (is_dec |=>
    status_reg[ST_ZERO] == (work_reg == 8'h00)) else $error("decrement zero flag wrong");
  a_skip_flags: assert property (is_dsk |=> $stable(status_reg))
    else $error("decrement-skip changed status");
  a_skip_zero: assert property (is_dsk && !instr_word[5] |=>
    flush_active == (work_reg == 8'h00)) else $error("decrement-skip flush wrong");
  a_jump_target: assert property (is_jmp |=>
    flush_active && program_counter == $past(jump_dest)) else $error("jump target wrong");
  a_jump_drop: assert property (s_jump_slot |=>
    !flush_active && program_counter == $past(program_counter) + 11'h001)
    else $error("jump slot not dropped");
endmodule // frj_exec_monitor

`default_nettype wire

// ### sim/frj_exec_test.sv
// Self-checking bench for the file-register and jump execution block.
// Drives instruction stream and register port itself; no partner model.
`timescale 1ns/1ps
`default_nettype none

module frj_exec_test;
  import frj_pkg::*;

  // Design inputs, all driven from time zero
  logic        ref_clk     = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        instr_valid = 1'b0;
  logic [11:0] instr_word  = 12'h000;
  logic [7:0]  reg_addr    = 8'h00;
  logic [7:0]  reg_wdata   = 8'h00;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  // Design outputs
  logic [7:0]  reg_rdata, work_reg, status_reg, watchdog_counter, prescaler;
  logic [10:0] program_counter;
  logic        flush_active;
  // Bookkeeping
  int          fail_count = 0;
  int          num_checks = 0;
  logic [10:0] exp_pc;
  logic [7:0]  exp_st, rd_val;

  frj_exec DUT (.ref_clk, .sys_rst, .instr_valid, .instr_word, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .program_counter, .work_reg, .status_reg,
    .watchdog_counter, .prescaler, .flush_active);

  // 40 MHz clock
  initial forever #12.5 ref_clk = ~ref_clk;

  // Hang guard; the run needs far fewer cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Port write; strobe dropped on the edge after, so tasks never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // Port read; data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // One instruction word, then the fetch address it must leave
  task automatic run(input logic [11:0] w, input logic [10:0] pc_e);
    @(posedge ref_clk);
    instr_word  <= w;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1 chk("program_counter", pc_e, program_counter);
    exp_pc = pc_e;
  endtask

  // Two words on consecutive edges, then the fetch address after both
  task automatic run_pair(input logic [11:0] w1, input logic [11:0] w2,
                          input logic [10:0] pc_e);
    @(posedge ref_clk);
    instr_word  <= w1;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    instr_word  <= w2;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1 chk("program_counter", pc_e, program_counter);
    exp_pc = pc_e;
  endtask

  function automatic logic [7:0] f_res(input int k, input logic [7:0] v);
    return (k == 0) ? 8'h00 : (k == 1) ? ~v : v - 8'h01;
  endfunction

  function automatic logic [11:0] f_word(input int k, input logic d, input logic [4:0] f);
    case (k)
      0: return {OP_CLEAR_HI, f};
      1: return {OP_INVERT_HI, d, f};
      2: return {OP_DEC_HI, d, f};
      default: return {OP_DECSK_HI, d, f};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, file ops with corners, watchdog clear, jumps, port
  initial begin
    logic [4:0] f;
    logic [7:0] v, w0, r;
    logic [8:0] k9;
    logic       d;
    int         k;
    void'($urandom(32'h7680));
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    exp_pc = PROG_RST;
    exp_st = STATUS_RST;
    #1 chk("status_reset", STATUS_RST, status_reg);
    chk("work_reset", ZERO_BYTE, work_reg);
    // First eight passes hit results of zero for each operation
    for (int i = 0; i < 48; i++) begin
      f  = 5'($urandom);
      v  = (i < 4) ? 8'h01 : (i < 8) ? 8'hff : (i == 8) ? 8'h00 : 8'($urandom);
      k  = (i < 9) ? ((i == 8) ? 2 : i % 4) : int'($urandom % 4);
      d  = (i < 4) ? 1'b0 : 1'($urandom);
      w0 = 8'($urandom);
      r  = f_res(k, v);
      wr({3'b000, f}, v);
      wr(OFS_WORK, w0);
      run(f_word(k, d, f), exp_pc + 11'h001);
      if (k != 3) exp_st[ST_ZERO] = (r == 8'h00);
      chk("status_reg", exp_st, status_reg);
      chk("flush_active", (k == 3 && r == 8'h00), flush_active);
      if (k == 3 && r == 8'h00) begin
        run(f_word(0, 1'b0, f), exp_pc + 11'h001);
        chk("flush_active", 11'h000, flush_active);
        chk("status_reg", exp_st, status_reg);
      end
      rd({3'b000, f});
      chk("file_reg", (k == 0 || d) ? r : v, rd_val);
      chk("work_reg", (k == 0 || d) ? w0 : r, work_reg);
    end
    // Watchdog clear with the prescaler on the tick counter, then on the watchdog
    for (int s = 0; s < 2; s++) begin
      v = 8'($urandom) | 8'h01;
      wr(OFS_OPTION, s ? 8'hff : 8'hf7);
      wr(OFS_WATCHDOG, 8'h5a);
      wr(OFS_PRESCALE, v);
      wr(OFS_STATUS, exp_st & 8'he7);
      run(OP_WDOG_CLR, exp_pc + 11'h001);
      exp_st[4:3] = 2'b11;
      chk("watchdog_counter", 11'h000, watchdog_counter);
      chk("status_reg", exp_st, status_reg);
      chk("prescaler", s ? 8'h00 : v, prescaler);
    end
    // Jump on every page, last one to the top of the page; slot word dropped
    for (int p = 0; p < 4; p++) begin
      k9 = (p == 3) ? 9'h1ff : 9'($urandom);
      exp_st[6:5] = 2'(p);
      wr(OFS_STATUS, exp_st);
      wr(8'h00, 8'ha5);
      run({OP_JUMP_HI, k9}, {exp_st[6:5], k9});
      chk("flush_active", 11'h001, flush_active);
      run({OP_CLEAR_HI, 5'h00}, exp_pc + 11'h001);
      chk("flush_active", 11'h000, flush_active);
      rd(8'h00);
      chk("file_reg", 8'ha5, rd_val);
      // Slot word straight behind the jump, no idle cycle between them
      run_pair({OP_JUMP_HI, k9}, {OP_CLEAR_HI, 5'h00}, {exp_st[6:5], k9} + 11'h001);
      chk("flush_active", 11'h000, flush_active);
      rd(8'h00);
      chk("file_reg", 8'ha5, rd_val);
    end
    // Port corners: unmapped read, read-only fetch address, status readback
    rd(8'h40);
    chk("unmapped_read", 11'h000, rd_val);
    wr(OFS_PROG_LO, 8'h33);
    #1 chk("program_counter", exp_pc, program_counter);
    rd(OFS_STATUS);
    chk("status_read", exp_st, rd_val);
    print_verdict();
  end
endmodule // frj_exec_test

bind frj_exec frj_exec_monitor u_mon (.ref_clk, .sys_rst, .instr_valid, .instr_word,
  .program_counter, .work_reg, .status_reg, .watchdog_counter, .flush_active);

`default_nettype wire
